/* mrp_packer.sv */
// Purpose: builds media root thread payload registers per macroblock
// Assumes: inputs synchronous to i_ref_clk; one command at a time
// Notes: one register leaves per handshake; gaps are sent as zeros
`timescale 1ns/10ps
`include "mrp_defs.svh"
// Behaviour
// - Intra DC precision in bits 14:13
// - Bit 12 disables mismatch control
// - Block presence mask in bits 11:6
// - Quantizer scaling type in bit 5
// - Quantizer scale code in bits 4:0
// - Reference field selects in bits 31:28
// - Second field bit, zero unless P field
// - Motion kind in bits 25:24
// - Transform type bit 21, zero without blocks
// - Backward vector flag in bit 18
// - Forward vector flag in bit 17
// - Intra flag bit 16; thread ignores mask
// - Coded blocks four registers each
// - Even row low words, odd row high
// - Header, constants, then in-line block
// - Vectors at m+2, four or two registers
// - Weight-offset pair at m+p+2, p>=n
// - Residual m+q+2 to m+q+13, q>=p+2
// - Dependency id in header bits 23:16
// - Return-buffer handle in header bits 15:0
// - Scoreboard mask 31:28 ANDed with i_ext_sb_mask
// - Dependency color in bits 27:26
// - Picture structure decides motion kind meaning
module mrp_packer (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input mrp_pkg::mrp_cmd_s i_cmd,
	output logic o_cmd_ready,
	input wire logic [3:0] i_ext_sb_mask,
	input mrp_pkg::mrp_row_s i_row,
	output logic o_row_ready,
	input mrp_pkg::mrp_beat_s i_data,
	output logic o_data_ready,
	output mrp_pkg::mrp_out_s o_out,
	input wire logic i_out_ready,
	output logic o_motion_16x8,
	output logic o_busy
);
	import mrp_pkg::*;
	mrp_top_s st_r;
	mrp_top_s st_nxt;
	mrp_beat_s coef_reg;
	logic free;

	// ----------------------------------------------------------------
	// Field assembly
	// ----------------------------------------------------------------
	function automatic logic [4:0] blk_regs(input logic [5:0] cbp);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 6; i++) begin
			n = n + {4'h0, cbp[i]};
		end
		blk_regs = n * `MRP_REGS_PER_BLK;
	endfunction

	function automatic logic [255:0] vld_ctl(input mrp_vld_s v);
		logic [31:0] w0;
		logic [31:0] w2;
		logic [255:0] r;
		w0 = 32'h0;
		w2 = 32'h0;
		r = 256'h0;
		w0[`MRP_B_REF_SEL +: 4] = v.reference_field_select;
		w0[`MRP_B_SECOND] = v.second_field_flag &&
			v.coding_type == `MRP_P_PICTURE &&
			v.motion_kind == `MRP_MK_FIELD;
		w0[`MRP_B_MOTION +: 2] = v.motion_kind;
		w0[`MRP_B_XFORM] = v.field_transform && (v.cbp != 6'h00);
		w0[`MRP_B_BACK] = v.backward;
		w0[`MRP_B_FWD] = v.forward;
		w0[`MRP_B_INTRA] = v.intra;
		w2[`MRP_B_CODING +: 2] = v.coding_type;
		w2[`MRP_B_PIC +: 2] = v.pic_struct;
		w2[`MRP_B_DCPREC +: 2] = v.dc_prec;
		w2[`MRP_B_NOMISM] = v.no_mismatch;
		// presence mask, luma 0 at top bit
		w2[`MRP_B_CBP +: 6] = v.cbp;
		w2[`MRP_B_QTYPE] = v.quantizer_scaling_type;
		w2[`MRP_B_QCODE +: 5] = v.q_code;
		r[`MRP_DW0 +: 32] = w0;
		r[`MRP_DW2 +: 32] = w2;
		vld_ctl = r;
	endfunction

	function automatic logic [255:0] avc_hdr(input mrp_avc_s a);
		logic [255:0] r;
		r = 256'h0;
		r[`MRP_B_HANDLE +: 16] = a.handle;
		r[`MRP_B_DID +: 8] = `MRP_HAS_SB ? a.thread_dependency_id : 8'h00;
		r[`MRP_B_SBMASK +: 4] = a.sb_mask;
		r[`MRP_B_COLOR +: 2] = a.color;
		avc_hdr = r;
	endfunction

	function automatic mrp_sect_e sect_of(input logic [7:0] r,
		input mrp_avc_s a);
		logic [7:0] m;
		logic [7:0] p;
		logic [7:0] q;
		logic [7:0] n;
		m = {2'h0, a.m};
		p = {2'h0, a.p};
		q = {2'h0, a.q};
		n = a.mv32 ? `MRP_MV_REGS_32 : `MRP_MV_REGS_16;
		sect_of = MRP_S_GAP;
		if (r == `MRP_HDR_REG) begin
			sect_of = MRP_S_HDR;
		end else if (r <= m + 8'h01) begin
			sect_of = MRP_S_DATA;
		end else if (r < m + `MRP_MV_BASE + n) begin
			sect_of = MRP_S_DATA;
		// pair at m+p+2; p below n would overlap
		end else if (r >= m + p + 8'h02 &&
			r < m + p + 8'h02 + `MRP_WO_REGS) begin
			sect_of = MRP_S_DATA;
		end else if (r >= m + q + 8'h02) begin
			sect_of = MRP_S_DATA;
		end
	endfunction

	// ----------------------------------------------------------------
	// Row pairing
	// ----------------------------------------------------------------
	mrp_row_pair u_pair (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_row(i_row),
		.o_ready(o_row_ready),
		.o_reg(coef_reg),
		.i_take(st_r.coef_take)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		free = !st_r.out.valid || i_out_ready;
		if (st_r.out.valid && i_out_ready) begin
			st_nxt.out.valid = 1'b0;
		end
		case (st_r.state)
			MRP_IDLE: begin
				st_nxt.cmd_ready = 1'b1;
				if (i_cmd.valid && st_r.cmd_ready) begin
					st_nxt.cmd_ready = 1'b0;
					st_nxt.avc = i_cmd.avc;
					st_nxt.vld = i_cmd.vld;
					st_nxt.av = i_cmd.av;
					st_nxt.av.sb_mask = i_cmd.av.sb_mask & i_ext_sb_mask;
					st_nxt.left = blk_regs(i_cmd.vld.cbp);
					// frame picture gives frame, else 16x8
					st_nxt.is_16x8 = !i_cmd.avc &&
						i_cmd.vld.motion_kind == `MRP_MK_FRAME16 &&
						i_cmd.vld.pic_struct != MRP_PS_FRAME;
					st_nxt.idx = i_cmd.avc ? `MRP_HDR_REG : `MRP_VLD_CTL_REG;
					st_nxt.state = i_cmd.avc ? MRP_AVC : MRP_VLD_CTL;
				end
			end
			MRP_VLD_CTL: begin
				if (free) begin
					st_nxt.out.valid = 1'b1;
					st_nxt.out.index = st_r.idx;
					st_nxt.out.data = vld_ctl(st_r.vld);
					st_nxt.out.last = (st_r.left == 5'h00);
					st_nxt.idx = `MRP_COEF_BASE;
					st_nxt.state = (st_r.left == 5'h00) ? MRP_DONE :
						MRP_VLD_COEF;
				end
			end
			MRP_VLD_COEF: begin
				st_nxt.coef_take = free;
				// only coded blocks, in arrival order
				if (st_r.coef_take && coef_reg.valid) begin
					st_nxt.coef_take = 1'b0;
					st_nxt.out.valid = 1'b1;
					st_nxt.out.index = st_r.idx;
					st_nxt.out.data = coef_reg.data;
					st_nxt.out.last = (st_r.left == 5'h01);
					st_nxt.idx = st_r.idx + 8'h01;
					st_nxt.left = st_r.left - 5'h01;
					if (st_r.left == 5'h01) begin
						st_nxt.state = MRP_DONE;
					end
				end
			end
			MRP_AVC: begin
				st_nxt.data_ready = 1'b0;
				case (sect_of(st_r.idx, st_r.av))
					MRP_S_HDR: begin
						if (free) begin
							st_nxt.out.valid = 1'b1;
							st_nxt.out.data = avc_hdr(st_r.av);
						end
					end
					MRP_S_DATA: begin
						st_nxt.data_ready = free && !st_r.data_ready;
						if (st_r.data_ready && i_data.valid) begin
							st_nxt.data_ready = 1'b0;
							st_nxt.out.valid = 1'b1;
							st_nxt.out.data = i_data.data;
						end
					end
					default: begin
						// Gaps go out as zeros to keep contents known
						if (free) begin
							st_nxt.out.valid = 1'b1;
							st_nxt.out.data = 256'h0;
						end
					end
				endcase
				if (st_nxt.out.valid && !st_r.out.valid ||
					st_nxt.out.valid && i_out_ready) begin
					st_nxt.out.index = st_r.idx;
					st_nxt.out.last = (st_r.idx ==
						{2'h0, st_r.av.m} + {2'h0, st_r.av.q} + `MRP_RES_LAST);
					st_nxt.idx = st_r.idx + 8'h01;
					if (st_nxt.out.last) begin
						st_nxt.state = MRP_DONE;
					end
				end
			end
			MRP_DONE: begin
				st_nxt.coef_take = 1'b0;
				st_nxt.data_ready = 1'b0;
				if (!st_nxt.out.valid) begin
					st_nxt.state = MRP_IDLE;
					st_nxt.cmd_ready = 1'b1;
				end
			end
			default: begin
				st_nxt.state = MRP_IDLE;
			end
		endcase
		st_nxt.busy = (st_nxt.state != MRP_IDLE);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_cmd_ready = st_r.cmd_ready;
	assign o_data_ready = st_r.data_ready;
	assign o_out = st_r.out;
	assign o_motion_16x8 = st_r.is_16x8;
	assign o_busy = st_r.busy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_dc_prec;
		st_r.out.valid && !st_r.avc && st_r.out.index == `MRP_VLD_CTL_REG
		|-> st_r.out.data[`MRP_DW2 + `MRP_B_DCPREC +: 2] == st_r.vld.dc_prec;
	endproperty
	a_dc_prec: assert property (p_dc_prec)
		else $error("dc precision misplaced");

	property p_mask;
		st_r.out.valid && !st_r.avc && st_r.out.index == `MRP_VLD_CTL_REG
		|-> st_r.out.data[`MRP_DW2 + `MRP_B_CBP +: 6] == st_r.vld.cbp;
	endproperty
	a_mask: assert property (p_mask)
		else $error("block mask misplaced");

	property p_second;
		st_r.out.valid && !st_r.avc && st_r.out.index == `MRP_VLD_CTL_REG &&
		st_r.vld.motion_kind != `MRP_MK_FIELD
		|-> !st_r.out.data[`MRP_B_SECOND];
	endproperty
	a_second: assert property (p_second)
		else $error("second field set without field prediction");

	property p_xform;
		st_r.out.valid && !st_r.avc && st_r.out.index == `MRP_VLD_CTL_REG &&
		st_r.vld.cbp == 6'h00 |-> !st_r.out.data[`MRP_B_XFORM];
	endproperty
	a_xform: assert property (p_xform)
		else $error("transform type set with no blocks");

	property p_coef_idx;
		st_r.out.valid && !st_r.avc && st_r.out.index != `MRP_VLD_CTL_REG
		|-> st_r.out.index >= `MRP_COEF_BASE &&
			st_r.out.index < `MRP_COEF_BASE + {3'h0, blk_regs(st_r.vld.cbp)};
	endproperty
	a_coef_idx: assert property (p_coef_idx)
		else $error("coefficient register out of range");

	property p_hdr;
		st_r.out.valid && st_r.avc && st_r.out.index == `MRP_HDR_REG
		|-> st_r.out.data[15:0] == st_r.av.handle &&
			st_r.out.data[31:24] == 8'h00;
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header handle or reserved bits wrong");

	property p_sbmask;
		$rose(o_busy) && st_r.avc ##[1:40] st_r.out.valid &&
		st_r.out.index == `MRP_HDR_REG |->
		st_r.out.data[`MRP_B_SBMASK +: 4] == st_r.av.sb_mask &&
		st_r.out.data[`MRP_B_COLOR +: 2] == st_r.av.color;
	endproperty
	a_sbmask: assert property (p_sbmask)
		else $error("scoreboard mask or color wrong");

	property p_last;
		st_r.out.valid && st_r.out.last && st_r.avc |->
		st_r.out.index == {2'h0, st_r.av.m} + {2'h0, st_r.av.q} +
			`MRP_RES_LAST;
	endproperty
	a_last: assert property (p_last)
		else $error("residual section ends at wrong register");

	property p_hold;
		st_r.out.valid && !i_out_ready |=>
		st_r.out.valid && $stable(st_r.out.data) && $stable(st_r.out.index);
	endproperty
	a_hold: assert property (p_hold)
		else $error("register changed while stalled");

	c_vld_coef: cover property (st_r.out.valid && !st_r.avc &&
		st_r.out.last && st_r.out.index > `MRP_COEF_BASE);
	c_vld_empty: cover property (st_r.out.valid && !st_r.avc &&
		st_r.out.last && st_r.out.index == `MRP_VLD_CTL_REG);
	c_avc_done: cover property (st_r.out.valid && st_r.avc &&
		st_r.out.last);
	c_avc_gap: cover property (st_r.state == MRP_AVC &&
		sect_of(st_r.idx, st_r.av) == MRP_S_GAP);
endmodule

/* mrp_defs.svh */
// Purpose: constants of the root thread payload packer
// Assumes: one payload register is 256 bits, sixteen 16-bit words
// Notes: bit positions are relative to the dword or register named
`ifndef MRP_DEFS_SVH
`define MRP_DEFS_SVH
// ----------------------------------------------------------------
// Decode-mode payload
// ----------------------------------------------------------------
`define MRP_VLD_CTL_REG 8'h01
`define MRP_COEF_BASE 8'h02
`define MRP_REGS_PER_BLK 5'h04
`define MRP_DW0 0
`define MRP_DW2 64
`define MRP_B_REF_SEL 28
`define MRP_B_SECOND 27
`define MRP_B_MOTION 24
`define MRP_B_XFORM 21
`define MRP_B_BACK 18
`define MRP_B_FWD 17
`define MRP_B_INTRA 16
`define MRP_B_CODING 18
`define MRP_B_PIC 16
`define MRP_B_DCPREC 13
`define MRP_B_NOMISM 12
`define MRP_B_CBP 6
`define MRP_B_QTYPE 5
`define MRP_B_QCODE 0
`define MRP_P_PICTURE 2'h2
`define MRP_MK_FIELD 2'h1
`define MRP_MK_FRAME16 2'h2
// ----------------------------------------------------------------
// Inverse-transform payload
// ----------------------------------------------------------------
`define MRP_HDR_REG 8'h00
`define MRP_B_HANDLE 0
`define MRP_B_DID 16
`define MRP_B_SBMASK 60
`define MRP_B_COLOR 58
`define MRP_HAS_SB 1'b1
`define MRP_MV_REGS_32 8'h04
`define MRP_MV_REGS_16 8'h02
`define MRP_MV_BASE 8'h02
`define MRP_WO_REGS 8'h02
`define MRP_RES_LAST 8'h0d
`endif

/* mrp_pkg.sv */
// Purpose: types shared by the payload packer modules
// Assumes: nothing beyond the constants header
// Notes: command fields arrive as one struct with its valid
package mrp_pkg;
	typedef enum logic [2:0] {
		MRP_IDLE = 3'h0,
		MRP_VLD_CTL = 3'h1,
		MRP_VLD_COEF = 3'h2,
		MRP_AVC = 3'h3,
		MRP_DONE = 3'h4
	} mrp_state_e;
	typedef enum logic [1:0] {
		MRP_PS_RSV = 2'h0,
		MRP_PS_TOP = 2'h1,
		MRP_PS_BOT = 2'h2,
		MRP_PS_FRAME = 2'h3
	} mrp_pic_e;
	typedef enum logic [1:0] {
		MRP_S_HDR = 2'h0,
		MRP_S_DATA = 2'h1,
		MRP_S_GAP = 2'h2
	} mrp_sect_e;
	typedef struct packed {
		logic [1:0] dc_prec;
		logic no_mismatch;
		logic [5:0] cbp;
		logic quantizer_scaling_type;
		logic [4:0] q_code;
		logic [3:0] reference_field_select;
		logic second_field_flag;
		logic [1:0] motion_kind;
		logic field_transform;
		logic backward;
		logic forward;
		logic intra;
		logic [1:0] pic_struct;
		logic [1:0] coding_type;
	} mrp_vld_s;
	typedef struct packed {
		logic [5:0] m;
		logic mv32;
		logic [5:0] p;
		logic [5:0] q;
		logic [15:0] handle;
		logic [7:0] thread_dependency_id;
		logic [3:0] sb_mask;
		logic [1:0] color;
	} mrp_avc_s;
	typedef struct packed {
		logic valid;
		logic avc;
		mrp_vld_s vld;
		mrp_avc_s av;
	} mrp_cmd_s;
	typedef struct packed {
		logic valid;
		logic [255:0] data;
	} mrp_beat_s;
	typedef struct packed {
		logic valid;
		logic [7:0][15:0] coef;
	} mrp_row_s;
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] index;
		logic [255:0] data;
	} mrp_out_s;
	typedef struct packed {
		logic have_even;
		logic [7:0][15:0] even;
		logic in_ready;
		mrp_beat_s out;
	} mrp_pair_s;
	typedef struct packed {
		mrp_state_e state;
		logic avc;
		mrp_vld_s vld;
		mrp_avc_s av;
		logic [7:0] idx;
		logic [4:0] left;
		mrp_out_s out;
		logic cmd_ready;
		logic data_ready;
		logic coef_take;
		logic is_16x8;
		logic busy;
	} mrp_top_s;
endpackage

/* mrp_row_pair.sv */
// Purpose: joins an even and an odd coefficient row into one register
// Assumes: rows arrive in order, even row first
// Notes: input ready drops while a packed register waits
`timescale 1ns/10ps
`include "mrp_defs.svh"
module mrp_row_pair (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input mrp_pkg::mrp_row_s i_row,
	output logic o_ready,
	output mrp_pkg::mrp_beat_s o_reg,
	input wire logic i_take
);
	import mrp_pkg::*;
	mrp_pair_s st_r;
	mrp_pair_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (st_r.out.valid && i_take) begin
			st_nxt.out.valid = 1'b0;
		end
		if (i_row.valid && st_r.in_ready) begin
			if (!st_r.have_even) begin
				st_nxt.even = i_row.coef;
				st_nxt.have_even = 1'b1;
			end else begin
				st_nxt.out.data = {i_row.coef, st_r.even};
				st_nxt.out.valid = 1'b1;
				st_nxt.have_even = 1'b0;
			end
		end
		// Only one packed register is held, so stall the rows
		st_nxt.in_ready = !st_nxt.out.valid;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_ready = st_r.in_ready;
	assign o_reg = st_r.out;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_row_order;
		$rose(st_r.out.valid) |->
			st_r.out.data[127:0] == $past(st_r.even);
	endproperty
	a_row_order: assert property (p_row_order)
		else $error("even row not in low words");
endmodule

/* mrp_sink_model.sv */
// Purpose: receiving thread model that takes payload registers
// Assumes: one register is taken per handshake on the output port
// Notes: slow mode stalls every other cycle so output hold is exercised
`timescale 1ns/10ps
module mrp_sink_model
	import mrp_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input mrp_pkg::mrp_out_s i_out,
	input wire logic i_slow,
	output logic o_ready
);
	logic [255:0] got_data[$];
	logic [7:0] got_idx[$];
	logic got_last[$];
	logic phase_r;
	// ----------------------------------------------------------------
	// Acceptance
	// ----------------------------------------------------------------
	// contents stored as given; the mask is not consulted here
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			phase_r <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			phase_r <= ~phase_r;
			o_ready <= ~i_slow | phase_r;
			if (i_out.valid && o_ready) begin
				got_data.push_back(i_out.data);
				got_idx.push_back(i_out.index);
				got_last.push_back(i_out.last);
			end
		end
	end
endmodule

/* media_root_thread_payload_packer_tb.sv */
// Purpose: self-checking bench for the payload packer
// Assumes: the sink model stands for the receiving thread
// Notes: expected registers are rebuilt here from the field layouts
`timescale 1ns/10ps
module media_root_thread_payload_packer_tb;
	import mrp_pkg::*;
	logic ref_clk;
	logic rst;
	logic slow;
	logic [3:0] ext_mask;
	mrp_cmd_s cmd;
	mrp_row_s row;
	mrp_beat_s beat;
	mrp_out_s out;
	logic out_ready;
	logic cmd_ready;
	logic row_ready;
	logic data_ready;
	logic motion_16x8;
	logic busy;
	int bad_count;
	int num_checks;
	int cycles;
	logic [255:0] exp_q[$];

	mrp_packer dut (
		.i_ref_clk(ref_clk),
		.i_rst(rst),
		.i_cmd(cmd),
		.o_cmd_ready(cmd_ready),
		.i_ext_sb_mask(ext_mask),
		.i_row(row),
		.o_row_ready(row_ready),
		.i_data(beat),
		.o_data_ready(data_ready),
		.o_out(out),
		.i_out_ready(out_ready),
		.o_motion_16x8(motion_16x8),
		.o_busy(busy)
	);
	mrp_sink_model snk (
		.i_ref_clk(ref_clk),
		.i_rst(rst),
		.i_out(out),
		.i_slow(slow),
		.o_ready(out_ready)
	);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(string what, logic [255:0] exp, logic [255:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(string what, logic exp, logic got);
		chk(what, {255'h0, exp}, {255'h0, got});
	endtask
	task automatic final_report();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run needs a few hundred cycles; this ceiling cuts a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// Stimulus sources
	// ----------------------------------------------------------------
	function automatic logic [15:0] cval(int b, int r, int c);
		return {4'ha, 4'(b), 4'(r), 4'(c)};
	endfunction
	function automatic logic [255:0] bval(int k);
		return {32{8'(k + 8'h40)}};
	endfunction
	task automatic send_cmd(mrp_cmd_s c);
		mrp_cmd_s idle;
		idle = mrp_cmd_s'(~c);
		idle.valid = 1'b0;
		cmd <= c;
		for (int k = 0; k < 200; k++) begin
			@(posedge ref_clk);
			if (cmd_ready === 1'b1) break;
		end
		cmd <= idle;
	endtask
	task automatic feed_rows(logic [5:0] cbp);
		mrp_row_s v;
		v = '0;
		for (int b = 0; b < 6; b++) begin
			if (cbp[5 - b]) begin
				for (int r = 0; r < 8; r++) begin
					for (int c = 0; c < 8; c++) begin
						v.coef[c] = cval(b, r, c);
					end
					v.valid = 1'b1;
					row <= v;
					do begin
						@(posedge ref_clk);
					end while (row_ready !== 1'b1);
				end
			end
		end
		v.coef = ~v.coef;
		v.valid = 1'b0;
		row <= v;
	endtask
	task automatic feed_data(int n);
		mrp_beat_s v;
		v = '0;
		for (int k = 0; k < n; k++) begin
			v.valid = 1'b1;
			v.data = bval(k);
			beat <= v;
			do begin
				@(posedge ref_clk);
			end while (data_ready !== 1'b1);
		end
		v.data = ~v.data;
		v.valid = 1'b0;
		beat <= v;
	endtask
	// Waits for every expected register, then for the return to idle
	task automatic collect(int first);
		int n;
		n = exp_q.size();
		for (int k = 0; k < 3000 && snk.got_data.size() < n; k++) begin
			@(posedge ref_clk);
		end
		chk("register count", 256'(n), 256'(snk.got_data.size()));
		for (int i = 0; i < n && i < snk.got_data.size(); i++) begin
			chk("register index", 256'(first + i), 256'(snk.got_idx[i]));
			chk("register data", exp_q[i], snk.got_data[i]);
			chk1("last flag", i == n - 1, snk.got_last[i]);
		end
		for (int k = 0; k < 100 && cmd_ready !== 1'b1; k++) begin
			@(posedge ref_clk);
		end
		chk1("busy after end", 1'b0, busy);
		@(posedge ref_clk);
		snk.got_data.delete();
		snk.got_idx.delete();
		snk.got_last.delete();
		exp_q.delete();
	endtask
	// ----------------------------------------------------------------
	// Payload scenarios
	// ----------------------------------------------------------------
	task automatic run_vld(mrp_vld_s v, logic sl, logic m16);
		mrp_cmd_s c;
		logic [255:0] w;
		slow <= sl;
		w = '0;
		w[31:28] = v.reference_field_select;
		// only a P picture with field motion keeps it
		w[27] = v.second_field_flag & (v.coding_type == 2'h2)
			& (v.motion_kind == 2'h1);
		w[25:24] = v.motion_kind;
		// zero when no block is coded
		w[21] = v.field_transform & (v.cbp != 6'h00);
		w[18] = v.backward;
		w[17] = v.forward;
		w[16] = v.intra;
		w[83:82] = v.coding_type;
		w[81:80] = v.pic_struct;
		w[78:77] = v.dc_prec;
		w[76] = v.no_mismatch;
		w[75:70] = v.cbp;
		w[69] = v.quantizer_scaling_type;
		w[68:64] = v.q_code;
		exp_q.push_back(w);
		// coded blocks only, two rows per register
		for (int b = 0; b < 6; b++) begin
			if (v.cbp[5 - b]) begin
				for (int j = 0; j < 4; j++) begin
					for (int x = 0; x < 16; x++) begin
						w[16 * x +: 16] = cval(b, 2 * j + x / 8, x % 8);
					end
					exp_q.push_back(w);
				end
			end
		end
		c = '0;
		c.valid = 1'b1;
		c.vld = v;
		fork
			feed_rows(v.cbp);
		join_none
		send_cmd(c);
		@(posedge ref_clk);
		chk1("busy", 1'b1, busy);
		chk1("cmd ready while busy", 1'b0, cmd_ready);
		chk1("16x8 motion", m16, motion_16x8);
		collect(1);
	endtask
	task automatic run_avc(mrp_avc_s a, logic [3:0] ext, logic sl);
		mrp_cmd_s c;
		logic [255:0] w;
		int n;
		int k;
		slow <= sl;
		ext_mask <= ext;
		n = a.mv32 ? 4 : 2;
		w = '0;
		w[15:0] = a.handle;
		w[23:16] = a.thread_dependency_id;
		w[63:60] = a.sb_mask & ext;
		w[59:58] = a.color;
		exp_q.push_back(w);
		k = 0;
		// data sections in order, gaps as zeros
		for (int r = 1; r <= a.m + a.q + 13; r++) begin
			if (r <= a.m + 1 + n || r >= a.m + a.q + 2 ||
				(r >= a.m + a.p + 2 && r <= a.m + a.p + 3)) begin
				exp_q.push_back(bval(k));
				k++;
			end else begin
				exp_q.push_back('0);
			end
		end
		c = '0;
		c.valid = 1'b1;
		c.avc = 1'b1;
		c.av = a;
		fork
			feed_data(k);
		join_none
		send_cmd(c);
		@(posedge ref_clk);
		chk1("busy", 1'b1, busy);
		collect(0);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		slow = 1'b0;
		ext_mask = 4'h0;
		cmd = '0;
		row = '0;
		beat = '0;
		repeat (10) @(posedge ref_clk);
		chk1("ready in reset", 1'b0, cmd_ready);
		chk1("valid in reset", 1'b0, out.valid);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk1("ready after reset", 1'b1, cmd_ready);
		run_vld('{2'h3, 1'b1, 6'h20, 1'b1, 5'h1f, 4'ha, 1'b1, 2'h1, 1'b1,
			1'b1, 1'b0, 1'b0, 2'h1, 2'h2}, 1'b1, 1'b0);
		run_vld('{2'h0, 1'b0, 6'h00, 1'b0, 5'h01, 4'h5, 1'b1, 2'h2, 1'b1,
			1'b0, 1'b1, 1'b0, 2'h2, 2'h3}, 1'b0, 1'b1);
		run_vld('{2'h1, 1'b0, 6'h11, 1'b0, 5'h10, 4'h3, 1'b1, 2'h3, 1'b0,
			1'b1, 1'b1, 1'b1, 2'h3, 2'h2}, 1'b1, 1'b0);
		// offsets kept legal: p at least n, q at least p+2
		run_avc('{6'd1, 1'b0, 6'd3, 6'd6, 16'hbeef, 8'h5a, 4'hc, 2'h2},
			4'h6, 1'b1);
		run_avc('{6'd0, 1'b1, 6'd4, 6'd6, 16'h0001, 8'hff, 4'hf, 2'h1},
			4'h9, 1'b0);
		final_report();
	end
endmodule
